//--- rtl/sflash_pkg.sv
// Shared constants and types for the serial flash command front end
package sflash_pkg;
  // ----------------------------------------
  // Instruction codes
  // ----------------------------------------
  localparam logic [7:0] OP_WREN  = 8'h06;
  localparam logic [7:0] OP_VWREN = 8'h50;
  localparam logic [7:0] OP_WRDI  = 8'h04;
  localparam logic [7:0] OP_RDSR1 = 8'h05;
  localparam logic [7:0] OP_RDSR2 = 8'h35;
  localparam logic [7:0] OP_RDSR3 = 8'h15;
  localparam logic [7:0] OP_WRSR1 = 8'h01;
  localparam logic [7:0] OP_WRSR2 = 8'h31;
  localparam logic [7:0] OP_WRSR3 = 8'h11;
  localparam logic [7:0] OP_PP    = 8'h02;
  localparam logic [7:0] OP_QPP   = 8'h32;
  localparam logic [7:0] OP_SECPP = 8'h42;
  localparam logic [7:0] OP_SECER = 8'h44;
  localparam logic [7:0] OP_SE    = 8'h20;
  localparam logic [7:0] OP_BE32  = 8'h52;
  localparam logic [7:0] OP_BE64  = 8'hD8;
  localparam logic [7:0] OP_CE1   = 8'hC7;
  localparam logic [7:0] OP_CE2   = 8'h60;
  localparam logic [7:0] OP_DOR   = 8'h3B;
  localparam logic [7:0] OP_QOR   = 8'h6B;
  localparam logic [7:0] OP_DIOR  = 8'hBB;
  localparam logic [7:0] OP_QIOR  = 8'hEB;
  localparam logic [7:0] OP_DIOID = 8'h92;
  localparam logic [7:0] OP_QIOID = 8'h94;
  localparam logic [7:0] OP_WRAP  = 8'h77;
  // ----------------------------------------
  // Frame geometry
  // ----------------------------------------
  localparam logic [4:0] ADDR_BITS   = 5'h18;
  localparam logic [4:0] BYTE_BITS   = 5'h08;
  localparam logic [4:0] CMD_LAST    = 5'h07;
  localparam logic [3:0] DUMMY_FAST  = 4'h8;
  localparam logic [3:0] DUMMY_QIO   = 4'h4;
  localparam logic [4:0] WRAP_SAMPLE = 5'h06;
  localparam logic [4:0] WRAP_CLKS   = 5'h08;
  localparam logic [7:0] SEC_HI      = 8'h00;
  localparam logic [7:0] SEC1_MID    = 8'h10;
  localparam logic [7:0] SEC2_MID    = 8'h20;
  localparam logic [7:0] SEC3_MID    = 8'h30;
  // ----------------------------------------
  // Status bits and register map
  // ----------------------------------------
  localparam int         BUSY_BIT  = 0;
  localparam int         LATCH_BIT = 1;
  localparam int         QGATE_BIT = 1;
  localparam logic [7:0] SR2_RST   = 8'h00;
  localparam logic [7:0] SR3_RST   = 8'h00;
  localparam logic [2:0] REG_STAT1 = 3'h0;
  localparam logic [2:0] REG_STAT2 = 3'h1;
  localparam logic [2:0] REG_STAT3 = 3'h2;
  localparam logic [2:0] REG_WRAP  = 3'h3;
  localparam logic [2:0] REG_LAST  = 3'h4;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {LW1 = 2'b00, LW2 = 2'b01, LW4 = 2'b10} lane_w_t;
  typedef enum logic [1:0] {SRC_MEM = 2'b00, SRC_STAT = 2'b01, SRC_ID = 2'b10} src_t;
  typedef enum logic [2:0] {
    ST_CMD = 3'b000, ST_ADDR = 3'b001, ST_MODE = 3'b010, ST_DUMMY = 3'b011,
    ST_DIN = 3'b100, ST_DOUT = 3'b101, ST_WRAP = 3'b110, ST_HOLD = 3'b111
  } state_t;
  typedef struct packed {
    logic       known;
    logic       has_addr;
    lane_w_t    addr_w;
    logic       has_mode;
    logic [3:0] dummy;
    logic       din;
    logic       dout;
    lane_w_t    data_w;
    src_t       src;
    logic       need_quad;
  } dec_t;
  typedef struct packed {
    logic [7:0]  op;
    logic [23:0] addr;
    logic [1:0]  sec;
  } array_cmd_t;
endpackage

//--- rtl/sflash_front_end.sv
// Multi-lane serial flash instruction front end, sampled on the system clock
// Notes on behaviour
// - All bytes move most significant bit first on every lane width.
// - Status and identification bytes repeat until select is released.
// - Program takes 1 to 256 bytes; extra bytes wrap within the page.
// - Security registers: A23-16 zero, A15-8 is 10h, 20h or 30h.
// - Two-lane address: lane one odd bits, lane zero even bits.
// - Two-lane output: bits 7,5,3,1 on lane one, 6,4,2,0 on zero.
// - Four-lane data: two clocks per byte, high nibble first.
// - Four-lane address: lanes zero to three carry bits 4-7, then 0-3.
// - Wrap setup: wrap bits 4-6 on lanes 0-2 in seventh clock.
// - 3Bh: single-lane command and address, 8 dummies, dual data out.
// - BBh and 92h: dual address and mode, then data or ID bytes.
// - 32h: single-lane command and address, then quad data in.
// - 6Bh: single-lane address, eight dummy clocks, quad data out.
// - EBh and 94h: quad address, mode, two dummy bytes, then data.
// - Write enable sets the write latch flag.
// - Program and erase need the write latch flag set; status write needs it or the volatile arm.
// - Volatile write enable leaves the latch flag alone, arms status write.
// - Write disable clears the write latch flag.
// - Latch flag clears at reset and when writes or erases complete.
// - Status reads shift the chosen register out on falling edges.
// - Status reads are honoured even while the array is busy.
// - Four-lane reads are refused unless the quad gate bit is set.
`timescale 1ns/1ps
`default_nettype none
module sflash_front_end #(
  parameter logic [7:0] MAKER_CODE  = 8'h5A,  // Arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'hA5   // Arbitrary value
) (
  // Clock and reset
  input  wire logic              mclk_i,
  input  wire logic              rst_n_i,
  // Serial link pins
  input  wire logic              select_n_i,
  input  wire logic              sclk_i,
  input  wire logic [3:0]        lane_i,
  output logic      [3:0]        lane_o,
  output logic      [3:0]        lane_oe_o,
  // Register port
  input  wire logic [2:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [7:0]        reg_rdata_o,
  // Array core side
  input  wire logic              busy_i,
  input  wire logic              done_i,
  output logic                   cmd_valid_o,
  output sflash_pkg::array_cmd_t cmd_o,
  output logic                   prog_load_o,
  output logic      [23:0]       prog_addr_o,
  output logic      [7:0]        prog_data_o,
  output logic                   rd_req_o,
  output logic      [23:0]       rd_addr_o,
  input  wire logic [7:0]        rd_data_i
);
  import sflash_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [4:0] lanes_of(input lane_w_t w);
    unique case (w)
      LW1: lanes_of = 5'h01;
      LW2: lanes_of = 5'h02;
      LW4: lanes_of = 5'h04;
      default: lanes_of = 5'h01;
    endcase
  endfunction

  // Lane order keeps the earliest bit highest in the word
  function automatic logic [23:0] shift_in(input logic [23:0] sh,
                                           input logic [3:0] l,
                                           input lane_w_t w);
    unique case (w)
      LW1: shift_in = {sh[22:0], l[0]};
      LW2: shift_in = {sh[21:0], l[1], l[0]};
      LW4: shift_in = {sh[19:0], l[3:0]};
      default: shift_in = sh;
    endcase
  endfunction

  function automatic dec_t decode(input logic [7:0] op);
    dec_t d;
    d = '0;
    d.known = 1'b1;
    case (op)
      OP_WREN, OP_VWREN, OP_WRDI, OP_CE1, OP_CE2, OP_WRAP: ;
      OP_RDSR1, OP_RDSR2, OP_RDSR3: begin
        d.dout = 1'b1;
        d.src  = SRC_STAT;
      end
      OP_WRSR1, OP_WRSR2, OP_WRSR3: d.din = 1'b1;
      OP_PP, OP_SECPP: begin
        d.has_addr = 1'b1;
        d.din      = 1'b1;
      end
      OP_QPP: begin
        d.has_addr = 1'b1;
        d.din      = 1'b1;
        d.data_w   = LW4;
      end
      OP_SE, OP_BE32, OP_BE64, OP_SECER: d.has_addr = 1'b1;
      OP_DOR, OP_QOR: begin
        d.has_addr  = 1'b1;
        d.dummy     = DUMMY_FAST;
        d.dout      = 1'b1;
        d.data_w    = (op == OP_DOR) ? LW2 : LW4;
        d.need_quad = (op == OP_QOR);
      end
      OP_DIOR, OP_DIOID: begin
        d.has_addr = 1'b1;
        d.addr_w   = LW2;
        d.has_mode = 1'b1;
        d.dout     = 1'b1;
        d.data_w   = LW2;
        d.src      = (op == OP_DIOID) ? SRC_ID : SRC_MEM;
      end
      OP_QIOR, OP_QIOID: begin
        d.has_addr  = 1'b1;
        d.addr_w    = LW4;
        d.has_mode  = 1'b1;
        d.dummy     = DUMMY_QIO;
        d.dout      = 1'b1;
        d.data_w    = LW4;
        d.src       = (op == OP_QIOID) ? SRC_ID : SRC_MEM;
        d.need_quad = 1'b1;
      end
      default: d.known = 1'b0;
    endcase
    return d;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] sclk_s;
  logic [2:0] csn_s;
  logic [3:0] lane_s1;
  logic [3:0] lane_s2;

  // Two flops each; third stage only for edge finding
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sclk_s  <= 3'h0;
      csn_s   <= 3'h7;
      lane_s1 <= 4'h0;
      lane_s2 <= 4'h0;
    end else begin
      sclk_s  <= {sclk_s[1:0], sclk_i};
      csn_s   <= {csn_s[1:0], select_n_i};
      lane_s1 <= lane_i;
      lane_s2 <= lane_s1;
    end
  end

  logic sel;
  logic rise_e;
  logic fall_e;
  logic cs_rise;
  assign sel     = ~csn_s[1];
  assign rise_e  = sel & sclk_s[1] & ~sclk_s[2];
  assign fall_e  = sel & ~sclk_s[1] & sclk_s[2];
  assign cs_rise = csn_s[1] & ~csn_s[2];

  // ----------------------------------------
  // Link sequencer
  // ----------------------------------------
  state_t      state_r;
  state_t      prev_r;
  dec_t        dec_r;
  dec_t        cmd_dec;
  logic [7:0]  op_r;
  logic [7:0]  op_nxt;
  logic [23:0] sh_r;
  logic [23:0] addr_r;
  logic [7:0]  mode_r;
  logic [4:0]  bitcnt_r;
  logic        ok_r;
  logic [2:0]  wrap_tmp_r;
  logic        latch_r;
  logic        vol_arm_r;
  logic [7:0]  sr2_r;
  logic [7:0]  sr3_r;
  logic        qgate;
  state_t      after_cmd;
  logic        ok_cmd;
  state_t      after_addr;
  state_t      after_mode;
  logic [23:0] sh_cur;
  logic [23:0] sh_dat;
  logic [4:0]  aw;
  logic [4:0]  dw;
  logic        din_done;

  assign op_nxt   = {sh_r[6:0], lane_s2[0]};
  assign cmd_dec  = decode(op_nxt);
  assign qgate    = sr2_r[QGATE_BIT];
  assign aw       = lanes_of(dec_r.addr_w);
  assign dw       = lanes_of(dec_r.data_w);
  assign sh_cur   = shift_in(sh_r, lane_s2, dec_r.addr_w);
  assign sh_dat   = shift_in(sh_r, lane_s2, dec_r.data_w);
  assign din_done = rise_e && state_r == ST_DIN && (bitcnt_r + dw) == BYTE_BITS;

  // First phase after the opcode byte
  always_comb begin
    ok_cmd = 1'b0;
    if (!cmd_dec.known) begin
      after_cmd = ST_HOLD;
    end else if (busy_i && !(cmd_dec.dout && cmd_dec.src == SRC_STAT)) begin
      after_cmd = ST_HOLD;
    end else if (cmd_dec.need_quad && !qgate) begin
      after_cmd = ST_HOLD;
    end else if (op_nxt == OP_WRAP) begin
      after_cmd = ST_WRAP;
    end else if (cmd_dec.has_addr) begin
      after_cmd = ST_ADDR;
    end else if (cmd_dec.dout) begin
      after_cmd = ST_DOUT;
    end else if (cmd_dec.din) begin
      after_cmd = ST_DIN;
    end else begin
      after_cmd = ST_HOLD;
      ok_cmd    = 1'b1;
    end
  end

  // Phases after address and mode
  always_comb begin
    if (dec_r.dummy != 4'h0) begin
      after_mode = ST_DUMMY;
    end else begin
      after_mode = ST_DOUT;
    end
    if (dec_r.has_mode) begin
      after_addr = ST_MODE;
    end else if (dec_r.dout) begin
      after_addr = after_mode;
    end else if (dec_r.din) begin
      after_addr = ST_DIN;
    end else begin
      after_addr = ST_HOLD;
    end
  end

  // Input sampled on link rising edges only
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state_r    <= ST_CMD;
      dec_r      <= '0;
      op_r       <= 8'h00;
      sh_r       <= 24'h000000;
      addr_r     <= 24'h000000;
      mode_r     <= 8'h00;
      bitcnt_r   <= 5'h00;
      ok_r       <= 1'b0;
      wrap_tmp_r <= 3'h0;
    end else if (!sel) begin
      state_r  <= ST_CMD;
      bitcnt_r <= 5'h00;
      ok_r     <= 1'b0;
    end else if (rise_e) begin
      unique case (state_r)
        ST_CMD: begin
          sh_r <= {sh_r[22:0], lane_s2[0]};
          if (bitcnt_r == CMD_LAST) begin
            op_r     <= op_nxt;
            dec_r    <= cmd_dec;
            bitcnt_r <= 5'h00;
            state_r  <= after_cmd;
            ok_r     <= ok_cmd;
          end else begin
            bitcnt_r <= bitcnt_r + 5'h01;
          end
        end
        // address on lane width of the command
        ST_ADDR: begin
          sh_r <= sh_cur;
          if ((bitcnt_r + aw) == ADDR_BITS) begin
            addr_r   <= sh_cur;
            bitcnt_r <= 5'h00;
            state_r  <= after_addr;
            ok_r     <= !dec_r.dout && !dec_r.din;
          end else begin
            bitcnt_r <= bitcnt_r + aw;
          end
        end
        ST_MODE: begin
          sh_r <= sh_cur;
          if ((bitcnt_r + aw) == BYTE_BITS) begin
            mode_r   <= sh_cur[7:0];
            bitcnt_r <= 5'h00;
            state_r  <= after_mode;
          end else begin
            bitcnt_r <= bitcnt_r + aw;
          end
        end
        ST_DUMMY: begin
          if ((bitcnt_r[3:0] + 4'h1) == dec_r.dummy) begin
            bitcnt_r <= 5'h00;
            state_r  <= ST_DOUT;
          end else begin
            bitcnt_r <= bitcnt_r + 5'h01;
          end
        end
        ST_DIN: begin
          sh_r     <= sh_dat;
          bitcnt_r <= din_done ? 5'h00 : bitcnt_r + dw;
        end
        ST_WRAP: begin
          if (bitcnt_r == WRAP_SAMPLE) begin
            wrap_tmp_r <= lane_s2[2:0];
          end
          if ((bitcnt_r + 5'h01) == WRAP_CLKS) begin
            state_r <= ST_HOLD;
            ok_r    <= 1'b1;
          end else begin
            bitcnt_r <= bitcnt_r + 5'h01;
          end
        end
        ST_DOUT, ST_HOLD: ;
      endcase
    end
  end

  // ----------------------------------------
  // Program data and status write bytes
  // ----------------------------------------
  logic [7:0] page_off_r;
  logic [1:0] nbytes_r;
  logic [7:0] wb0_r;
  logic [7:0] wb1_r;
  logic       is_prog;
  logic [1:0] sec_idx;
  logic       sec_ok;
  logic       commit;

  assign is_prog = (op_r == OP_PP) || (op_r == OP_QPP) || (op_r == OP_SECPP);

  always_comb begin
    sec_idx = 2'h0;
    if (addr_r[23:16] == SEC_HI) begin
      if (addr_r[15:8] == SEC1_MID) sec_idx = 2'h1;
      if (addr_r[15:8] == SEC2_MID) sec_idx = 2'h2;
      if (addr_r[15:8] == SEC3_MID) sec_idx = 2'h3;
    end
  end
  assign sec_ok = !(op_r == OP_SECPP || op_r == OP_SECER) || sec_idx != 2'h0;

  assign commit = (state_r == ST_HOLD && ok_r) || (state_r == ST_DIN && nbytes_r != 2'h0);

  // Bytes land in the core page buffer; core acts only on the command
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      page_off_r  <= 8'h00;
      nbytes_r    <= 2'h0;
      wb0_r       <= 8'h00;
      wb1_r       <= 8'h00;
      prog_load_o <= 1'b0;
      prog_addr_o <= 24'h000000;
      prog_data_o <= 8'h00;
    end else begin
      prog_load_o <= 1'b0;
      if (!sel) begin
        page_off_r <= 8'h00;
        nbytes_r   <= 2'h0;
      end else if (din_done) begin
        page_off_r <= page_off_r + 8'h01;
        if (nbytes_r != 2'h3) nbytes_r <= nbytes_r + 2'h1;
        if (nbytes_r == 2'h0) wb0_r <= sh_dat[7:0];
        if (nbytes_r == 2'h1) wb1_r <= sh_dat[7:0];
        prog_load_o <= is_prog && latch_r && sec_ok;
        prog_addr_o <= {addr_r[23:8], addr_r[7:0] + page_off_r};
        prog_data_o <= sh_dat[7:0];
      end
    end
  end

  // ----------------------------------------
  // Write latch flag
  // ----------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      latch_r   <= 1'b0;
      vol_arm_r <= 1'b0;
    end else begin
      if (done_i) latch_r <= 1'b0;
      if (cs_rise && commit) begin
        unique case (op_r)
          OP_WREN: latch_r <= 1'b1;
          OP_WRDI: latch_r <= 1'b0;
          OP_VWREN: vol_arm_r <= 1'b1;
          OP_WRSR1, OP_WRSR2, OP_WRSR3: begin
            latch_r   <= 1'b0;
            vol_arm_r <= 1'b0;
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Core commands, status and wrap setting
  // ----------------------------------------
  logic [2:0] wrap_r;
  logic [7:0] last_op_r;
  logic       is_array_op;

  assign is_array_op = is_prog || op_r == OP_SE || op_r == OP_BE32 ||
                       op_r == OP_BE64 || op_r == OP_SECER ||
                       op_r == OP_CE1 || op_r == OP_CE2;

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      cmd_valid_o <= 1'b0;
      cmd_o       <= '0;
      sr2_r       <= SR2_RST;
      sr3_r       <= SR3_RST;
      wrap_r      <= 3'h0;
      last_op_r   <= 8'h00;
    end else begin
      cmd_valid_o <= 1'b0;
      if (reg_wr_i && reg_addr_i == REG_STAT2) sr2_r <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == REG_STAT3) sr3_r <= reg_wdata_i;
      if (cs_rise && commit) begin
        last_op_r <= op_r;
        // array work gated by latch flag
        if (is_array_op && latch_r && sec_ok) begin
          cmd_valid_o <= 1'b1;
          cmd_o       <= '{op: op_r, addr: addr_r, sec: sec_idx};
        end
        if (op_r == OP_WRAP) wrap_r <= wrap_tmp_r;
        if (latch_r || vol_arm_r) begin
          if (op_r == OP_WRSR2) sr2_r <= wb0_r;
          if (op_r == OP_WRSR3) sr3_r <= wb0_r;
          if (op_r == OP_WRSR1 && nbytes_r > 2'h1) sr2_r <= wb1_r;
        end
      end
    end
  end

  // Software view; data valid only the cycle after the strobe
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        REG_STAT1: reg_rdata_o <= {6'h00, latch_r, busy_i};
        REG_STAT2: reg_rdata_o <= sr2_r;
        REG_STAT3: reg_rdata_o <= sr3_r;
        REG_WRAP:  reg_rdata_o <= {5'h00, wrap_r};
        REG_LAST:  reg_rdata_o <= last_op_r;
        default:   reg_rdata_o <= 8'h00;
      endcase
    end else begin
      reg_rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------
  // Output byte fetch
  // ----------------------------------------
  logic [7:0]  next_byte_r;
  logic [23:0] raddr_r;
  logic        id_dev_r;
  logic        fetch;
  logic        enter;
  logic [2:0]  ocnt_r;
  logic [7:0]  osh_r;
  logic [7:0]  cur_byte;
  logic [2:0]  olast;
  logic [7:0]  stat_sel;

  assign enter = state_r == ST_DOUT && prev_r != ST_DOUT;
  assign fetch = enter || (fall_e && state_r == ST_DOUT && ocnt_r == 3'h0);

  always_comb begin
    unique case (op_r)
      OP_RDSR2: stat_sel = sr2_r;
      OP_RDSR3: stat_sel = sr3_r;
      default:  stat_sel = {6'h00, latch_r, busy_i};
    endcase
  end

  // Prefetch one byte ahead so the falling edge never waits
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      prev_r      <= ST_CMD;
      next_byte_r <= 8'h00;
      raddr_r     <= 24'h000000;
      id_dev_r    <= 1'b0;
      rd_req_o    <= 1'b0;
      rd_addr_o   <= 24'h000000;
    end else begin
      prev_r   <= state_r;
      rd_req_o <= 1'b0;
      if (rd_req_o) next_byte_r <= rd_data_i;
      if (fetch) begin
        unique case (dec_r.src)
          SRC_MEM: begin
            rd_req_o  <= 1'b1;
            rd_addr_o <= enter ? addr_r : raddr_r;
            raddr_r   <= (enter ? addr_r : raddr_r) + 24'h000001;
          end
          SRC_STAT: next_byte_r <= stat_sel;
          SRC_ID: begin
            next_byte_r <= (id_dev_r && !enter) ? DEVICE_CODE : MAKER_CODE;
            id_dev_r    <= enter ? 1'b1 : !id_dev_r;
          end
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Lane drive on link falling edges
  // ----------------------------------------
  assign cur_byte = (ocnt_r == 3'h0) ? next_byte_r : osh_r;
  assign olast    = 3'(5'h08 / dw - 5'h01);

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      lane_o    <= 4'h0;
      lane_oe_o <= 4'h0;
      ocnt_r    <= 3'h0;
      osh_r     <= 8'h00;
    end else if (!sel || state_r != ST_DOUT) begin
      lane_oe_o <= 4'h0;
      lane_o    <= 4'h0;
      ocnt_r    <= 3'h0;
    end else if (fall_e) begin
      ocnt_r <= (ocnt_r == olast) ? 3'h0 : ocnt_r + 3'h1;
      unique case (dec_r.data_w)
        LW1: begin
          lane_o    <= {2'b00, cur_byte[7], 1'b0};
          lane_oe_o <= 4'b0010;
          osh_r     <= {cur_byte[6:0], 1'b0};
        end
        LW2: begin
          lane_o    <= {2'b00, cur_byte[7:6]};
          lane_oe_o <= 4'b0011;
          osh_r     <= {cur_byte[5:0], 2'b00};
        end
        LW4: begin
          lane_o    <= cur_byte[7:4];
          lane_oe_o <= 4'b1111;
          osh_r     <= {cur_byte[3:0], 4'h0};
        end
        default: ;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- sim/sflash_host_model.sv
// Host link model: select, link clock and lane drive
`timescale 1ns/1ps
`default_nettype none
module sflash_host (
  input  wire logic [3:0] dev_o,
  input  wire logic [3:0] dev_oe,
  output logic            select_n,
  output logic            sclk,
  output logic [3:0]      lane
);
  logic [3:0] hd = 4'h0;
  // Wire level: device wins where it drives, else host pattern
  assign lane = (dev_oe & dev_o) | (~dev_oe & hd);
  initial select_n = 1'h1;
  initial sclk = 1'h0;
  // Frame edge; clock stands low outside frames
  task sel(input logic v);
    select_n <= v;
    #160;
  endtask
  // msb first, earliest bits on highest lane
  task xb(input logic [7:0] d, input int w, output logic [7:0] q);
    for (int i = 0; i < 8; i += w) begin
      hd <= 4'(((32'(d) << i) & 32'hFF) >> (8 - w));
      #80;
      q = 8'((q << w) | (w == 1 ? 4'(lane[1]) : lane & 4'((1 << w) - 1)));
      sclk <= 1'h1;
      #80;
      sclk <= 1'h0;
    end
  endtask
endmodule
`default_nettype wire

//--- sim/sflash_front_end_asserts.sv
// Port checker for the flash front end
`timescale 1ns/1ps
`default_nettype none
module sflash_chk (
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  input wire logic       select_n_i,
  input wire logic       reg_rd_i,
  input wire logic [3:0] lane_oe_o,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       cmd_valid_o,
  input wire logic       prog_load_o,
  input wire logic       rd_req_o
);
  // ----------------
  // Port properties
  // ----------------
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  AST_RDZ: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00) else $error("stray rdata");
  AST_IDLE: assert property (select_n_i [*5] |-> lane_oe_o == 4'h0) else $error("oe idle");
  AST_START: assert property ($fell(select_n_i) |-> (lane_oe_o == 4'h0) [*3])
    else $error("oe at start");
  AST_COMMIT: assert property (cmd_valid_o |-> select_n_i) else $error("early commit");
  AST_LANES: assert property (lane_oe_o inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("lane mix");
  AST_CPULSE: assert property (cmd_valid_o |=> !cmd_valid_o) else $error("cmd pulse");
  AST_PPULSE: assert property (prog_load_o |=> !prog_load_o) else $error("load pulse");
  AST_RPULSE: assert property (rd_req_o |=> !rd_req_o) else $error("read pulse");
  // Main scenarios reached
  cover property (cmd_valid_o);
  cover property (rd_req_o);
  cover property (lane_oe_o == 4'hF);
endmodule
bind sflash_front_end sflash_chk sflash_chk_i (.mclk_i, .rst_n_i, .select_n_i, .reg_rd_i,
  .lane_oe_o, .reg_rdata_o, .cmd_valid_o, .prog_load_o, .rd_req_o);
`default_nettype wire

//--- sim/tb_sflash_front_end.sv
// Self-checking bench for the flash front end
`timescale 1ns/1ps
`default_nettype none
module tb_sflash_front_end;
  import sflash_pkg::*;
  localparam logic [7:0] MK = 8'h3C;  // Arbitrary value
  localparam logic [7:0] DV = 8'hC3;  // Arbitrary value
  logic        mclk_i = 1'h0, rst_n_i, reg_wr_i, reg_rd_i;
  logic        busy_i, done_i, select_n, sclk, cmd_valid_o, prog_load_o, rd_req_o;
  logic [2:0]  reg_addr_i;
  logic [3:0]  lane, lane_o, lane_oe_o;
  logic [7:0]  reg_wdata_i, rd_data_i, reg_rdata_o, prog_data_o, q, pd;
  logic [23:0] prog_addr_o, rd_addr_o;
  array_cmd_t  cmd_o;
  int          err_count = 0, checks_done = 0, nc = 0, cyc = 0;
  sflash_front_end #(.MAKER_CODE(MK), .DEVICE_CODE(DV)) sflash_front_end_i (
    .mclk_i, .rst_n_i, .select_n_i(select_n), .sclk_i(sclk), .lane_i(lane), .lane_o,
    .lane_oe_o, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .busy_i,
    .done_i, .cmd_valid_o, .cmd_o, .prog_load_o, .prog_addr_o, .prog_data_o, .rd_req_o,
    .rd_addr_o, .rd_data_i);
  sflash_host sflash_host_i (.dev_o(lane_o), .dev_oe(lane_oe_o), .select_n, .sclk, .lane);
  always #10 mclk_i = ~mclk_i;
  // Array model: data follows the requested address
  assign rd_data_i = rd_addr_o[7:0] ^ 8'hC6;
  // Commit count, program byte capture, hang limit
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (cmd_valid_o === 1'h1) nc <= nc + 1;
    if (prog_load_o === 1'h1) pd <= prog_data_o;
    if (cyc == 30000) begin
      err_count++;
      give_verdict;
    end
  end
  task give_verdict;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // Read data stands only in the cycle after the strobe
  task rr(input logic [2:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'h1;
    @(posedge mclk_i) reg_rd_i <= 1'h0;
    #1 chk("reg", e, reg_rdata_o);
  endtask
  task op1(input logic [7:0] c);
    sflash_host_i.sel(1'h0);
    sflash_host_i.xb(c, 1, q);
    sflash_host_i.sel(1'h1);
  endtask
  // Opens a frame: command, then address on w lanes
  task fr(input logic [7:0] c, input logic [23:0] a, input int w);
    sflash_host_i.sel(1'h0);
    sflash_host_i.xb(c, 1, q);
    for (int i = 2; i >= 0; i--) sflash_host_i.xb(a[8*i+:8], w, q);
  endtask
  task t_latch;
    op1(OP_WREN);
    rr(3'h0, 8'h02);
    op1(OP_VWREN);
    rr(3'h0, 8'h02);
    op1(OP_WRDI);
    rr(3'h0, 8'h00);
  endtask
  // Refused lanes float, so the host pattern comes back
  task t_quad(input logic [7:0] e);
    fr(OP_QOR, 24'h000100, 1);
    repeat (4) sflash_host_i.xb(8'h5A, 4, q);
    sflash_host_i.xb(8'h96, 4, q);
    chk("quad", e, q);
    sflash_host_i.sel(1'h1);
  endtask
  task t_stat;
    @(posedge mclk_i);
    reg_addr_i <= 3'h1;
    reg_wdata_i <= 8'h02;
    reg_wr_i <= 1'h1;
    @(posedge mclk_i) reg_wr_i <= 1'h0;
    rr(3'h1, 8'h02);
    rr(3'h5, 8'h00);
    @(posedge mclk_i) busy_i <= 1'h1;
    sflash_host_i.sel(1'h0);
    sflash_host_i.xb(OP_RDSR2, 1, q);
    sflash_host_i.xb(8'h96, 1, q);
    chk("stat", 8'h02, q);
    sflash_host_i.xb(8'h69, 1, q);
    chk("again", 8'h02, q);
    sflash_host_i.sel(1'h1);
    @(posedge mclk_i) busy_i <= 1'h0;
  endtask
  task t_dual;
    fr(OP_DOR, 24'h000200, 1);
    sflash_host_i.xb(8'h00, 1, q);
    sflash_host_i.xb(8'h96, 2, q);
    chk("dual", 8'hC6, q);
    sflash_host_i.xb(8'h69, 2, q);
    chk("dual2", 8'hC7, q);
    sflash_host_i.sel(1'h1);
  endtask
  task t_id;
    fr(OP_DIOID, 24'h000000, 2);
    sflash_host_i.xb(8'hF0, 2, q);
    sflash_host_i.xb(8'h96, 2, q);
    chk("maker", MK, q);
    sflash_host_i.xb(8'h69, 2, q);
    chk("device", DV, q);
    sflash_host_i.sel(1'h1);
  endtask
  task t_prog;
    fr(OP_QPP, 24'h000300, 1);
    sflash_host_i.xb(8'hA5, 4, q);
    sflash_host_i.sel(1'h1);
    chk("nolatch", 8'h00, 8'(nc));
    op1(OP_WREN);
    fr(OP_QPP, 24'h000300, 1);
    sflash_host_i.xb(8'h5E, 4, q);
    sflash_host_i.sel(1'h1);
    chk("data", 8'h5E, pd);
    chk("paddr", 8'h03, prog_addr_o[15:8]);
    chk("cmds", 8'h01, 8'(nc));
    chk("op", OP_QPP, cmd_o.op);
    chk("caddr", 8'h03, cmd_o.addr[15:8]);
    @(posedge mclk_i) done_i <= 1'h1;
    @(posedge mclk_i) done_i <= 1'h0;
    rr(3'h0, 8'h00);
  endtask
  // Main sequence
  initial begin
    {rst_n_i, reg_wr_i, reg_rd_i, busy_i, done_i} = 5'h00;
    reg_addr_i = 3'h0;
    reg_wdata_i = 8'h00;
    repeat (3) @(posedge mclk_i);
    rst_n_i <= 1'h1;
    @(posedge mclk_i);
    rr(3'h0, 8'h00);
    t_latch;
    t_quad(8'h96);
    t_stat;
    t_quad(8'hC6);
    t_dual;
    t_id;
    t_prog;
    give_verdict;
  end
endmodule
`default_nettype wire
